// >>> src/arpp_pkg.sv
// Package for the converter result post-processing block
package arpp_pkg;
  localparam int unsigned ADDR_W = 32;

  // Register byte addresses
  localparam logic [31:0] OFS_CUR_RES   = 32'hffff_0520;
  localparam logic [31:0] OFS_VLT_RES   = 32'hffff_0524;
  localparam logic [31:0] OFS_TMP_RES   = 32'hffff_0528;
  localparam logic [31:0] OFS_QUEUE     = 32'hffff_052c;
  localparam logic [31:0] OFS_CUR_TRIM  = 32'hffff_0530;
  localparam logic [31:0] OFS_VLT_TRIM  = 32'hffff_0534;
  localparam logic [31:0] OFS_RCNT_LIM  = 32'hffff_0548;
  localparam logic [31:0] OFS_RCNT_VAL  = 32'hffff_054c;
  localparam logic [31:0] OFS_THRESH    = 32'hffff_0550;
  localparam logic [31:0] OFS_THR_LIM   = 32'hffff_0554;
  localparam logic [31:0] OFS_THR_CNT   = 32'hffff_0558;
  localparam logic [31:0] OFS_CONFIG    = 32'hffff_0600;
  localparam logic [31:0] OFS_STATUS    = 32'hffff_0604;

  // Configuration field positions
  localparam int unsigned CFG_RCNT_EN   = 0;
  localparam int unsigned CFG_QUEUE_EN  = 1;
  localparam int unsigned CFG_OVR_EN    = 2;
  localparam int unsigned CFG_CMP_LO    = 3;
  localparam int unsigned CFG_CMP_HI    = 4;

  // Status bit positions
  localparam int unsigned ST_CUR_RDY    = 0;
  localparam int unsigned ST_VLT_RDY    = 1;
  localparam int unsigned ST_TMP_RDY    = 2;
  localparam int unsigned ST_THR_HIT    = 3;
  localparam int unsigned ST_OVR        = 4;
  localparam int unsigned ST_Q_NEMPTY   = 5;
  localparam int unsigned ST_Q_FULL     = 6;
  localparam int unsigned ST_Q_OVFL     = 7;

  // Reset values
  localparam logic [7:0]  CFG_RST       = 8'h00;
  localparam logic [15:0] RCNT_LIM_RST  = 16'h0001;
  localparam logic [15:0] THRESH_RST    = 16'h0000;
  localparam logic [7:0]  THR_LIM_RST   = 8'h01;
  localparam logic [15:0] TRIM_CUR_RST  = 16'h8000;
  localparam logic [15:0] TRIM_VLT_RST  = 16'h8000;

  // Comparator modes
  localparam logic [1:0]  CMP_OFF       = 2'h0;
  localparam logic [1:0]  CMP_LEVEL     = 2'h1;
  localparam logic [1:0]  CMP_CNT_CLR   = 2'h2;
  localparam logic [1:0]  CMP_CNT_DEC   = 2'h3;

  // Overrange timing
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned OVR_TIME_US   = 125;
  localparam int unsigned OVR_CYCLES    = OVR_TIME_US * (CLK_HZ / 1_000_000) + 1;

  localparam int unsigned Q_DEPTH       = 32;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } arpp_bus_req_t;

  typedef struct packed {
    logic        cur_vld;
    logic [15:0] cur;
    logic        vlt_vld;
    logic [15:0] vlt;
    logic        tmp_vld;
    logic [15:0] tmp;
    logic        cur_active;
    logic        overrange;
    logic        cal_cur_vld;
    logic        cal_vlt_vld;
    logic [15:0] cal_value;
  } arpp_conv_t;
endpackage

// >>> src/arpp_top.sv
// Result post-processing: comparator, counter, queue, result and trim registers
// Notes on behaviour
// - Mode 01: interrupt when absolute current result reaches threshold with threshold flag clear.
// - Mode 10: count hits, interrupt at limit, below-threshold clears count.
// - Mode 11: count hits, interrupt at limit, below-threshold decrements, floor zero.
// - Overrange flag set only after gross overrange persists over 125 us.
// - Queue enabled: paired current and voltage results stored, 32 entries.
// - Three status bits report queue condition.
// - Result count mode: interrupt only when count equals limit.
// - Count mode without queue keeps only latest current result.
// - Voltage and temperature keep converting; latest results retained.
// - Current result register frozen while current ready flag set.
// - Reading current result clears all three ready flags.
// - Voltage frozen while ready; read clears bits 2:1 if current idle.
// - Temperature frozen while ready; its read clears only its flag.
// - Queue read returns current in 15:0, voltage in 31:16.
// - Offset trims load default at reset, overwritten by calibration.
// - Mode 00: comparator off, no threshold interrupts.
// - Result count equal to limit resets count to zero, then resumes.
// - Threshold status asserts as soon as count equals limit.
`timescale 1ns/1ps
`default_nettype none
module arpp_top
  import arpp_pkg::*;
#(
  parameter int unsigned OVR_CNT = OVR_CYCLES
) (
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rst,
  // Register port
  input  wire arpp_pkg::arpp_bus_req_t bus_req,
  output logic [31:0]         bus_rdata,
  // Converter results
  input  wire arpp_pkg::arpp_conv_t    conv,
  // Interrupt request to core
  output logic                conv_irq
);
  import arpp_pkg::*;

  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  localparam int unsigned QA = $clog2(Q_DEPTH);

  typedef struct packed {
    logic [7:0]    cfg;
    logic [15:0]   rcnt_lim;
    logic [15:0]   rcnt_val;
    logic [15:0]   thresh;
    logic [7:0]    thr_lim;
    logic [7:0]    thr_cnt;
    logic [15:0]   cur_res;
    logic [15:0]   vlt_res;
    logic [15:0]   tmp_res;
    logic [15:0]   cur_trim;
    logic [15:0]   vlt_trim;
    logic [2:0]    rdy;
    logic          thr_hit;
    logic          ovr;
    logic          q_ovfl;
    logic [31:0]   ovr_cnt;
    logic [QA-1:0] q_wp;
    logic [QA-1:0] q_rp;
    logic [QA:0]   q_cnt;
    logic [31:0]   rdata;
    logic          irq;
  } arpp_state_t;

  arpp_state_t s_q;
  arpp_state_t s_d;
  logic [31:0] q_mem [Q_DEPTH];

  function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
    return bus_req.addr == o;
  endfunction

  function automatic logic [15:0] mag(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  logic [1:0] cmp_mode;
  logic       above;
  logic       q_push;
  logic       q_pop;
  logic       cur_upd;
  logic       rcnt_fire;

  assign cmp_mode  = s_q.cfg[CFG_CMP_HI:CFG_CMP_LO];
  assign above     = mag(conv.cur) >= s_q.thresh;
  assign q_push    = s_q.cfg[CFG_QUEUE_EN] && conv.cur_vld && conv.vlt_vld;
  assign q_pop     = bus_req.rd && hit(bus_req.addr, OFS_QUEUE) && (s_q.q_cnt != '0);
  assign rcnt_fire = s_q.cfg[CFG_RCNT_EN] && conv.cur_vld
                     && (16'(s_q.rcnt_val + 16'h0001) == s_q.rcnt_lim);
  // Count mode without queue: freshest result taken while current ready flag clear, flag raised at limit
  assign cur_upd   = conv.cur_vld && !s_q.rdy[ST_CUR_RDY];

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.rdata = 32'h0000_0000;
    // Register writes
    if (bus_req.wr) begin
      if (hit(bus_req.addr, OFS_CONFIG)) begin
        s_d.cfg      = bus_req.wdata[7:0];
        s_d.rcnt_val = 16'h0000;
        s_d.thr_cnt  = 8'h00;
        s_d.thr_hit  = 1'b0;
      end
      if (hit(bus_req.addr, OFS_RCNT_LIM)) s_d.rcnt_lim = bus_req.wdata[15:0];
      if (hit(bus_req.addr, OFS_THRESH))   s_d.thresh   = bus_req.wdata[15:0];
      if (hit(bus_req.addr, OFS_THR_LIM))  s_d.thr_lim  = bus_req.wdata[7:0];
      if (hit(bus_req.addr, OFS_CUR_TRIM)) s_d.cur_trim = bus_req.wdata[15:0];
      if (hit(bus_req.addr, OFS_VLT_TRIM)) s_d.vlt_trim = bus_req.wdata[15:0];
      if (hit(bus_req.addr, OFS_STATUS)) begin
        if (bus_req.wdata[ST_THR_HIT]) s_d.thr_hit = 1'b0;
        if (bus_req.wdata[ST_OVR])     s_d.ovr     = 1'b0;
        if (bus_req.wdata[ST_Q_OVFL])  s_d.q_ovfl  = 1'b0;
      end
    end
    // Calibration overwrite
    if (conv.cal_cur_vld) s_d.cur_trim = conv.cal_value;
    if (conv.cal_vlt_vld) s_d.vlt_trim = conv.cal_value;
    // Register reads and read side effects
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_CUR_RES: begin
          s_d.rdata = {16'h0000, s_q.cur_res};
          s_d.rdy   = 3'b000;
        end
        OFS_VLT_RES: begin
          s_d.rdata = {16'h0000, s_q.vlt_res};
          if (!conv.cur_active) s_d.rdy[ST_TMP_RDY:ST_VLT_RDY] = 2'b00;
        end
        OFS_TMP_RES: begin
          s_d.rdata = {16'h0000, s_q.tmp_res};
          s_d.rdy[ST_TMP_RDY] = 1'b0;
        end
        OFS_QUEUE:    s_d.rdata = (s_q.q_cnt != '0) ? q_mem[s_q.q_rp] : 32'h0000_0000;
        OFS_CUR_TRIM: s_d.rdata = {16'h0000, s_q.cur_trim};
        OFS_VLT_TRIM: s_d.rdata = {16'h0000, s_q.vlt_trim};
        OFS_RCNT_LIM: s_d.rdata = {16'h0000, s_q.rcnt_lim};
        OFS_RCNT_VAL: s_d.rdata = {16'h0000, s_q.rcnt_val};
        OFS_THRESH:   s_d.rdata = {16'h0000, s_q.thresh};
        OFS_THR_LIM:  s_d.rdata = {24'h00_0000, s_q.thr_lim};
        OFS_THR_CNT:  s_d.rdata = {24'h00_0000, s_q.thr_cnt};
        OFS_CONFIG:   s_d.rdata = {24'h00_0000, s_q.cfg};
        OFS_STATUS:   s_d.rdata = {24'h00_0000, s_q.q_ovfl, (s_q.q_cnt == 6'(Q_DEPTH)),
                                   (s_q.q_cnt != '0), s_q.ovr, s_q.thr_hit, s_q.rdy};
        default:      s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Result registers: set wins over a same-cycle read clear
    if (cur_upd) begin
      s_d.cur_res = conv.cur;
      if (!s_q.cfg[CFG_RCNT_EN] || rcnt_fire) s_d.rdy[ST_CUR_RDY] = 1'b1;
    end
    if (conv.vlt_vld && !s_q.rdy[ST_VLT_RDY]) begin
      s_d.vlt_res = conv.vlt;
      if (!s_q.cfg[CFG_RCNT_EN] || rcnt_fire) s_d.rdy[ST_VLT_RDY] = 1'b1;
    end
    if (conv.tmp_vld && !s_q.rdy[ST_TMP_RDY]) begin
      s_d.tmp_res = conv.tmp;
      if (!s_q.cfg[CFG_RCNT_EN] || rcnt_fire) s_d.rdy[ST_TMP_RDY] = 1'b1;
    end
    // Result counter
    if (s_q.cfg[CFG_RCNT_EN] && conv.cur_vld) begin
      if (rcnt_fire) begin
        s_d.rcnt_val = 16'h0000;
        s_d.irq      = 1'b1;
      end else begin
        s_d.rcnt_val = 16'(s_q.rcnt_val + 16'h0001);
      end
    end else if (!s_q.cfg[CFG_RCNT_EN] && conv.cur_vld) begin
      s_d.irq = 1'b1;
    end
    // Threshold comparator
    if (conv.cur_vld) begin
      unique case (cmp_mode)
        CMP_OFF: ;
        CMP_LEVEL: if (above) s_d.thr_hit = 1'b1;
        CMP_CNT_CLR, CMP_CNT_DEC: begin
          if (above) begin
            if (s_q.thr_cnt < s_q.thr_lim) s_d.thr_cnt = 8'(s_q.thr_cnt + 8'h01);
            if (8'(s_q.thr_cnt + 8'h01) >= s_q.thr_lim) s_d.thr_hit = 1'b1;
          end else if (cmp_mode == CMP_CNT_CLR) begin
            s_d.thr_cnt = 8'h00;
          end else if (s_q.thr_cnt != 8'h00) begin
            s_d.thr_cnt = 8'(s_q.thr_cnt - 8'h01);
          end
        end
      endcase
      if (s_d.thr_hit && !s_q.thr_hit) s_d.irq = 1'b1;
    end
    // Overrange persistence filter
    if (s_q.cfg[CFG_OVR_EN] && conv.overrange) begin
      if (s_q.ovr_cnt < OVR_CNT) s_d.ovr_cnt = s_q.ovr_cnt + 32'h0000_0001;
      else if (!s_q.ovr) begin
        s_d.ovr = 1'b1;
        s_d.irq = 1'b1;
      end
    end else begin
      s_d.ovr_cnt = 32'h0000_0000;
    end
    // Queue pointers
    if (q_push) begin
      s_d.q_wp = QA'(s_q.q_wp + 1'b1);
      if (s_q.q_cnt == 6'(Q_DEPTH)) s_d.q_ovfl = 1'b1;
    end
    if (q_pop) s_d.q_rp = QA'(s_q.q_rp + 1'b1);
    if (q_push && !q_pop && s_q.q_cnt != 6'(Q_DEPTH)) s_d.q_cnt = 6'(s_q.q_cnt + 6'h01);
    else if (q_pop && !q_push) s_d.q_cnt = 6'(s_q.q_cnt - 6'h01);
    if (!s_q.cfg[CFG_QUEUE_EN]) begin
      s_d.q_wp  = '0;
      s_d.q_rp  = '0;
      s_d.q_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q          <= '0;
      s_q.cfg      <= CFG_RST;
      s_q.rcnt_lim <= RCNT_LIM_RST;
      s_q.thresh   <= THRESH_RST;
      s_q.thr_lim  <= THR_LIM_RST;
      s_q.cur_trim <= TRIM_CUR_RST;
      s_q.vlt_trim <= TRIM_VLT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (q_push) q_mem[s_q.q_wp] <= {conv.vlt, conv.cur};
  end

  assign bus_rdata = s_q.rdata;
  assign conv_irq  = s_q.irq;

  // Checks
  chk_cur_frozen: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.rdy[ST_CUR_RDY] && !(bus_req.rd && bus_req.addr == OFS_CUR_RES)
    |=> $stable(s_q.cur_res)) else $error("current result changed while ready");
  chk_cur_read_clr: assert property (@(posedge clk_sys) disable iff (rst)
    bus_req.rd && bus_req.addr == OFS_CUR_RES && !conv.cur_vld
    && !conv.vlt_vld && !conv.tmp_vld |=> s_q.rdy == 3'b000)
    else $error("ready flags not cleared by current read");
  chk_tmp_read_clr: assert property (@(posedge clk_sys) disable iff (rst)
    bus_req.rd && bus_req.addr == OFS_TMP_RES && !conv.tmp_vld && !conv.cur_vld && !conv.vlt_vld
    |=> !s_q.rdy[ST_TMP_RDY] && s_q.rdy[1:0] == $past(s_q.rdy[1:0]))
    else $error("temperature read clear wrong");
  chk_mode_off: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_mode == CMP_OFF && !bus_req.wr |=> !$rose(s_q.thr_hit))
    else $error("threshold flag in mode off");
  chk_level_hit: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_mode == CMP_LEVEL && conv.cur_vld && above && !bus_req.wr |=> s_q.thr_hit)
    else $error("level compare missed");
  chk_cnt_clear: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_mode == CMP_CNT_CLR && conv.cur_vld && !above && !bus_req.wr |=> s_q.thr_cnt == 8'h00)
    else $error("count not cleared");
  chk_cnt_dec: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_mode == CMP_CNT_DEC && conv.cur_vld && !above && !bus_req.wr && s_q.thr_cnt != 8'h00
    |=> s_q.thr_cnt == $past(s_q.thr_cnt) - 8'h01) else $error("count not decremented");
  chk_cnt_sat: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.thr_cnt <= s_q.thr_lim || $past(bus_req.wr)) else $error("count above limit");
  chk_rcnt_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    rcnt_fire && !bus_req.wr |=> s_q.rcnt_val == 16'h0000 && conv_irq)
    else $error("result counter did not wrap");
  chk_ovr_delay: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(s_q.ovr) |-> $past(s_q.ovr_cnt) >= OVR_CNT) else $error("overrange too early");
  chk_q_order: assert property (@(posedge clk_sys) disable iff (rst)
    q_pop && !bus_req.wr |=> s_q.q_rp == QA'($past(s_q.q_rp) + 1'b1))
    else $error("queue pointer stuck");
  cov_level: cover property (@(posedge clk_sys) cmp_mode == CMP_LEVEL ##1 $rose(s_q.thr_hit));
  cov_qfull: cover property (@(posedge clk_sys) s_q.q_cnt == 6'(Q_DEPTH));
  cov_ovr:   cover property (@(posedge clk_sys) $rose(s_q.ovr));
  cov_rcnt:  cover property (@(posedge clk_sys) rcnt_fire);
  cov_vclr:  cover property (bus_req.rd && bus_req.addr == OFS_VLT_RES && !conv.cur_active);

  // Queue bookkeeping
  chk_q_push: assert property (q_push && !q_pop && !bus_req.wr
    && s_q.q_cnt != 6'(Q_DEPTH)
    |=> s_q.q_cnt == 6'($past(s_q.q_cnt) + 6'h01))
    else $error("queue count not raised");
  chk_q_pop: assert property (q_pop && !q_push && !bus_req.wr
    |=> s_q.q_cnt == 6'($past(s_q.q_cnt) - 6'h01))
    else $error("queue count not lowered");
  chk_q_empty_rd: assert property (bus_req.rd && bus_req.addr == OFS_QUEUE
    && s_q.cfg[CFG_QUEUE_EN] && s_q.q_cnt == '0
    |=> bus_rdata == 32'h0000_0000 && $stable(s_q.q_rp))
    else $error("empty queue read moved pointer");
  chk_q_off: assert property (!s_q.cfg[CFG_QUEUE_EN]
    |=> s_q.q_cnt == '0) else $error("disabled queue holds entries");
  chk_q_ovfl: assert property (q_push && s_q.q_cnt == 6'(Q_DEPTH)
    |=> s_q.q_ovfl) else $error("queue overflow not flagged");
  chk_q_word: assert property (q_push
    |=> q_mem[$past(s_q.q_wp)] == {$past(conv.vlt), $past(conv.cur)})
    else $error("queue word misplaced");

  // Register reads
  chk_status_rd: assert property (bus_req.rd && bus_req.addr == OFS_STATUS
    |=> bus_rdata[2:0] == $past(s_q.rdy) && bus_rdata[5] == ($past(s_q.q_cnt) != '0))
    else $error("status word wrong");
  chk_rd_idle: assert property (!bus_req.rd
    |=> bus_rdata == 32'h0000_0000) else $error("read data outside read cycle");
  chk_cur_rd: assert property (bus_req.rd && bus_req.addr == OFS_CUR_RES
    |=> bus_rdata == {16'h0000, $past(s_q.cur_res)})
    else $error("current result read wrong");

  // Result registers and ready flags
  chk_vlt_frozen: assert property (s_q.rdy[ST_VLT_RDY]
    |=> $stable(s_q.vlt_res)) else $error("voltage result changed while ready");
  chk_tmp_frozen: assert property (s_q.rdy[ST_TMP_RDY]
    |=> $stable(s_q.tmp_res)) else $error("temperature result changed while ready");
  chk_vlt_rd_clr: assert property (bus_req.rd && bus_req.addr == OFS_VLT_RES
    && !conv.cur_active && !conv.vlt_vld && !conv.tmp_vld
    |=> s_q.rdy[2:1] == 2'b00) else $error("voltage read did not clear flags");
  chk_vlt_rd_keep: assert property (bus_req.rd && bus_req.addr == OFS_VLT_RES
    && conv.cur_active && !conv.vlt_vld && !conv.tmp_vld
    |=> s_q.rdy[2:1] == $past(s_q.rdy[2:1])) else $error("voltage read cleared flags");
  chk_rdy_set: assert property (!s_q.cfg[CFG_RCNT_EN] && conv.cur_vld
    && !s_q.rdy[ST_CUR_RDY]
    |=> s_q.rdy[ST_CUR_RDY] && s_q.cur_res == $past(conv.cur))
    else $error("current result not taken");

  // Result counter
  chk_rcnt_step: assert property (s_q.cfg[CFG_RCNT_EN] && conv.cur_vld
    && !rcnt_fire && !bus_req.wr
    |=> s_q.rcnt_val == 16'($past(s_q.rcnt_val) + 16'h0001))
    else $error("result counter did not step");
  chk_rcnt_quiet: assert property (s_q.cfg[CFG_RCNT_EN] && conv.cur_vld
    && !rcnt_fire && !s_q.rdy[ST_CUR_RDY]
    |=> !s_q.rdy[ST_CUR_RDY]) else $error("ready raised before count limit");
  chk_plain_irq: assert property (!s_q.cfg[CFG_RCNT_EN] && conv.cur_vld
    |=> conv_irq) else $error("result interrupt missing");

  // Calibration and overrange
  chk_cal_cur: assert property (conv.cal_cur_vld
    |=> s_q.cur_trim == $past(conv.cal_value)) else $error("current trim not loaded");
  chk_cal_vlt: assert property (conv.cal_vlt_vld
    |=> s_q.vlt_trim == $past(conv.cal_value)) else $error("voltage trim not loaded");
  chk_ovr_irq: assert property ($rose(s_q.ovr)
    |-> conv_irq) else $error("overrange interrupt missing");
  chk_ovr_off: assert property (!s_q.cfg[CFG_OVR_EN]
    |=> s_q.ovr_cnt == 32'h0000_0000) else $error("overrange filter ran while off");

  // Threshold comparator
  chk_thr_irq: assert property ($rose(s_q.thr_hit)
    |-> conv_irq) else $error("threshold interrupt missing");
  chk_cnt_inc: assert property (cmp_mode[1] && conv.cur_vld && above && !bus_req.wr
    && s_q.thr_cnt < s_q.thr_lim
    |=> s_q.thr_cnt == 8'($past(s_q.thr_cnt) + 8'h01))
    else $error("threshold count not raised");
  chk_cnt_flag: assert property (cmp_mode[1] && conv.cur_vld && above
    && 8'(s_q.thr_cnt + 8'h01) >= s_q.thr_lim
    |=> s_q.thr_hit) else $error("threshold flag late");
  chk_level_cnt: assert property (cmp_mode == CMP_LEVEL && !bus_req.wr
    |=> $stable(s_q.thr_cnt)) else $error("level mode moved count");
endmodule
`default_nettype wire

// >>> tb/arpp_tb.sv
// Self-checking testbench for the result post-processing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import arpp_pkg::*;
  logic          clk_sys;
  logic          rst;
  arpp_bus_req_t req;
  logic [31:0]   rdata;
  arpp_conv_t    cv;
  logic          irq;
  int            n_errors = 0;
  int            total_checks = 0;
  int            n_irq;
  int            cyc = 0;
  int            base;
  logic [31:0]   rd_val;

  arpp_top #(.OVR_CNT(20)) DUT (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .bus_req   (req),
    .bus_rdata (rdata),
    .conv      (cv),
    .conv_irq  (irq)
  );

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  // Interrupt pulse counter
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      n_irq <= 0;
    else if (irq === 1'b1)
      n_irq <= n_irq + 1;
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_irq(input int exp);
    chk(32'(n_irq - base), 32'(exp));
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk_sys);
    req.wr    <= 1'b0;
    req.wdata <= ~d;
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_sys);
    req.rd   <= 1'b0;
    @(negedge clk_sys);
    rd_val = rdata;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_val & m, e);
  endtask

  // Result pulse: bit0 current, bit1 voltage, bit2 temperature
  task automatic res(input logic [2:0] w, input logic [15:0] c, input logic [15:0] v);
    @(posedge clk_sys);
    {cv.tmp_vld, cv.vlt_vld, cv.cur_vld} <= w;
    cv.cur <= c;
    cv.vlt <= v;
    cv.tmp <= v;
    @(posedge clk_sys);
    {cv.tmp_vld, cv.vlt_vld, cv.cur_vld} <= 3'h0;
    cv.cur <= ~c;
    cv.vlt <= ~v;
    cv.tmp <= ~v;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic hit(input logic [15:0] c);
    res(3'h1, c, 16'h0000);
    rd(OFS_CUR_RES);
  endtask

  task automatic cal(input logic [1:0] w, input logic [15:0] v);
    @(posedge clk_sys);
    {cv.cal_vlt_vld, cv.cal_cur_vld} <= w;
    cv.cal_value <= v;
    @(posedge clk_sys);
    {cv.cal_vlt_vld, cv.cal_cur_vld} <= 2'h0;
    cv.cal_value <= ~v;
  endtask

  task automatic ovr(input int n);
    @(posedge clk_sys);
    cv.overrange <= 1'b1;
    repeat (n) @(posedge clk_sys);
    cv.overrange <= 1'b0;
  endtask

  initial begin
    req = '0;
    cv = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values and unmapped read
    rchk(OFS_CUR_RES, 32'hffff_ffff, 32'h0000_0000);
    rchk(OFS_QUEUE, 32'hffff_ffff, 32'h0000_0000);
    rchk(OFS_CUR_TRIM, 32'h0000_ffff, {16'h0000, TRIM_CUR_RST});
    rchk(OFS_VLT_TRIM, 32'h0000_ffff, {16'h0000, TRIM_VLT_RST});
    rchk(OFS_RCNT_LIM, 32'h0000_ffff, 32'h0000_0001);
    rchk(32'hffff_0700, 32'hffff_ffff, 32'h0000_0000);
    // Trim write and calibration overwrite
    wr(OFS_CUR_TRIM, 32'h0000_1234);
    rchk(OFS_CUR_TRIM, 32'h0000_ffff, 32'h0000_1234);
    cal(2'h1, 16'h4321);
    cal(2'h2, 16'h5678);
    rchk(OFS_CUR_TRIM, 32'h0000_ffff, 32'h0000_4321);
    rchk(OFS_VLT_TRIM, 32'h0000_ffff, 32'h0000_5678);
    // Ready flags and frozen result registers
    cv.cur_active <= 1'b1;
    res(3'h7, 16'h0011, 16'h0022);
    rchk(OFS_STATUS, 32'h0000_0007, 32'h0000_0007);
    res(3'h1, 16'h0099, 16'h0000);
    rchk(OFS_CUR_RES, 32'h0000_ffff, 32'h0000_0011);
    rchk(OFS_STATUS, 32'h0000_0007, 32'h0000_0000);
    cv.cur_active <= 1'b0;
    res(3'h6, 16'h0000, 16'h0033);
    rchk(OFS_VLT_RES, 32'h0000_ffff, 32'h0000_0033);
    rchk(OFS_STATUS, 32'h0000_0007, 32'h0000_0000);
    res(3'h6, 16'h0000, 16'h0044);
    cv.cur_active <= 1'b1;
    rchk(OFS_TMP_RES, 32'h0000_ffff, 32'h0000_0044);
    rchk(OFS_STATUS, 32'h0000_0007, 32'h0000_0002);
    rd(OFS_CUR_RES);
    // Comparator modes against threshold 100
    wr(OFS_THRESH, 32'h0000_0064);
    wr(OFS_CONFIG, 32'h0000_0000);
    hit(16'hff6a);
    rchk(OFS_STATUS, 32'h0000_0008, 32'h0000_0000);
    wr(OFS_CONFIG, 32'h0000_0008);
    hit(16'hff6a);
    rchk(OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
    wr(OFS_STATUS, 32'h0000_0008);
    hit(16'h0063);
    rchk(OFS_STATUS, 32'h0000_0008, 32'h0000_0000);
    wr(OFS_THR_LIM, 32'h0000_0003);
    wr(OFS_CONFIG, 32'h0000_0010);
    hit(16'h0064);
    hit(16'h0064);
    hit(16'h0005);
    rchk(OFS_THR_CNT, 32'h0000_00ff, 32'h0000_0000);
    repeat (3) hit(16'hff00);
    rchk(OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
    hit(16'h00c8);
    rchk(OFS_THR_CNT, 32'h0000_00ff, 32'h0000_0003);
    wr(OFS_CONFIG, 32'h0000_0018);
    hit(16'h0064);
    hit(16'h0064);
    hit(16'h0005);
    rchk(OFS_THR_CNT, 32'h0000_00ff, 32'h0000_0001);
    hit(16'h0005);
    hit(16'h0005);
    rchk(OFS_THR_CNT, 32'h0000_00ff, 32'h0000_0000);
    rchk(OFS_STATUS, 32'h0000_0008, 32'h0000_0000);
    // Result count mode with limit 3
    wr(OFS_CONFIG, 32'h0000_0001);
    wr(OFS_RCNT_LIM, 32'h0000_0003);
    base = n_irq;
    res(3'h3, 16'h0101, 16'h0201);
    res(3'h3, 16'h0102, 16'h0202);
    chk_irq(0);
    rchk(OFS_RCNT_VAL, 32'h0000_ffff, 32'h0000_0002);
    res(3'h3, 16'h0103, 16'h0203);
    chk_irq(1);
    rchk(OFS_RCNT_VAL, 32'h0000_ffff, 32'h0000_0000);
    rchk(OFS_CUR_RES, 32'h0000_ffff, 32'h0000_0103);
    rchk(OFS_VLT_RES, 32'h0000_ffff, 32'h0000_0203);
    // Queue filled to 32 entries and drained
    wr(OFS_CONFIG, 32'h0000_0002);
    rchk(OFS_STATUS, 32'h0000_00e0, 32'h0000_0000);
    for (int i = 0; i < 32; i++)
      res(3'h3, 16'(i), 16'(i + 256));
    rchk(OFS_STATUS, 32'h0000_00e0, 32'h0000_0060);
    for (int i = 0; i < 32; i++)
      rchk(OFS_QUEUE, 32'hffff_ffff, {16'(i + 256), 16'(i)});
    rchk(OFS_STATUS, 32'h0000_00e0, 32'h0000_0000);
    // Overrange persistence
    ovr(30);
    rchk(OFS_STATUS, 32'h0000_0010, 32'h0000_0000);
    wr(OFS_CONFIG, 32'h0000_0004);
    ovr(10);
    rchk(OFS_STATUS, 32'h0000_0010, 32'h0000_0000);
    ovr(30);
    rchk(OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
    close_out();
  end
endmodule
`default_nettype wire
